// ===== design/ramp_seq_defines.svh
`ifndef RAMP_SEQ_DEFINES_SVH
`define RAMP_SEQ_DEFINES_SVH
// per-segment block: segment s at byte 0x100 + 0x20*s
`define SEG_BASE 12'h100
`define SEG_STRIDE_LOG2 5
`define SEG_OFF_STEP 3'h0
`define SEG_OFF_LEN 3'h1
`define SEG_OFF_CTRL 3'h2
// ctrl word fields
`define CTRL_FAST_BIT 0
`define CTRL_HALF_BIT 1
`define CTRL_CLEAR_BIT 2
`define CTRL_MARK_LSB 4
`define CTRL_ADV_LSB 8
`define CTRL_SUCC_LSB 12
// global registers
`define REG_ENABLE 12'h000
`define REG_LIMIT_LOW_L 12'h004
`define REG_LIMIT_LOW_H 12'h008
`define REG_LIMIT_HIGH_L 12'h00C
`define REG_LIMIT_HIGH_H 12'h010
`define REG_COUNT 12'h014
`define REG_STATUS 12'h018
`define REG_ACCUM_L 12'h01C
`define REG_ACCUM_H 12'h020
// reset values
`define LIMIT_LOW_RST 33'h000000000
`define LIMIT_HIGH_RST 33'h0FFFFFFFF
`endif

// ===== design/ramp_seq_pkg.sv
package ramp_seq_pkg;
  typedef enum logic [1:0] {
    adv_length = 2'b00,
    adv_event_a = 2'b01,
    adv_event_b = 2'b10,
    adv_event_c = 2'b11
  } adv_type;
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_run = 1'b1
  } state_type;
endpackage : ramp_seq_pkg

// ===== design/ramp_segment_sequencer.sv
`timescale 1ns/10ps
`include "ramp_seq_defines.svh"
`default_nettype none
module ramp_segment_sequencer
  import ramp_seq_pkg::*;
#(
  parameter int SEGS = 8,
  parameter int STEP_W = 30,
  parameter int LEN_W = 16,
  parameter int ACC_W = 33,
  parameter int CNT_W = 13
) (
  input wire logic i_mclk, // comparison clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  input wire logic i_event_a, // trigger event a pulse
  input wire logic i_event_b, // trigger event b pulse
  input wire logic i_event_c, // trigger event c pulse
  output logic o_marker_out_zero, // marker flag 0
  output logic o_marker_out_one, // marker flag 1
  output logic o_fast_settle, // fast-lock and slip reduction
  output logic [ACC_W-1:0] o_accum // ramp accumulator
);

  ////////////////////////////////////////////////////////////////////////
  logic [STEP_W-1:0] seg_step_value [SEGS];
  logic [LEN_W-1:0] seg_tick_count [SEGS];
  logic seg_fast_settle [SEGS];
  logic seg_half_rate [SEGS];
  logic seg_accum_clear [SEGS];
  logic [1:0] seg_marker_bits [SEGS];
  logic [1:0] seg_advance_source [SEGS];
  logic [2:0] seg_successor [SEGS];
  logic ramp_enable;
  logic [ACC_W-1:0] limit_low;
  logic [ACC_W-1:0] limit_high;
  logic [CNT_W-1:0] ramp_count_limit;
  logic [CNT_W-1:0] ramp_count;
  state_type state;
  logic [2:0] cur;
  logic [LEN_W:0] ticks_left;
  logic half_phase;
  logic enable_q;
  logic [ACC_W-1:0] accum;
  logic [2:0] rd_idx;

  ////////////////////////////////////////////////////////////////////////
  // address decoding
  function automatic logic in_seg_area(input logic [11:0] a);
    in_seg_area = (a[11:8] == 4'h1);
  endfunction : in_seg_area

  function automatic logic [2:0] seg_of(input logic [11:0] a);
    seg_of = a[`SEG_STRIDE_LOG2+2:`SEG_STRIDE_LOG2];
  endfunction : seg_of

  function automatic logic is_seg(input logic [11:0] a, input int s,
                                  input logic [2:0] off);
    is_seg = in_seg_area(a) && (seg_of(a) == 3'(s)) && (a[4:2] == off)
             && (a[1:0] == 2'h0);
  endfunction : is_seg

  function automatic logic mapped(input logic [11:0] a);
    mapped = in_seg_area(a) ? (a[4:2] <= `SEG_OFF_CTRL)
             : (a <= `REG_ACCUM_H && a[1:0] == 2'h0);
  endfunction : mapped

  wire logic acc_phase = i_psel && i_penable;
  wire logic setup_phase = i_psel && !i_penable;
  wire logic wr = acc_phase && i_pwrite && mapped(i_paddr);
  assign rd_idx = seg_of(i_paddr);

  ////////////////////////////////////////////////////////////////////////
  // segment storage
  // unaligned or unmapped writes are dropped
  generate
    for (genvar s = 0; s < SEGS; s++) begin : g_seg
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          seg_step_value[s] <= '0;
          seg_tick_count[s] <= '0;
          seg_fast_settle[s] <= 1'b0;
          seg_half_rate[s] <= 1'b0;
          seg_accum_clear[s] <= 1'b0;
          seg_marker_bits[s] <= 2'h0;
          seg_advance_source[s] <= 2'h0;
          seg_successor[s] <= 3'h0;
        end else if (wr) begin
          if (is_seg(i_paddr, s, `SEG_OFF_STEP))
            seg_step_value[s] <= i_pwdata[STEP_W-1:0];
          if (is_seg(i_paddr, s, `SEG_OFF_LEN))
            seg_tick_count[s] <= i_pwdata[LEN_W-1:0];
          if (is_seg(i_paddr, s, `SEG_OFF_CTRL)) begin
            seg_fast_settle[s] <= i_pwdata[`CTRL_FAST_BIT];
            seg_half_rate[s] <= i_pwdata[`CTRL_HALF_BIT];
            seg_accum_clear[s] <= i_pwdata[`CTRL_CLEAR_BIT];
            seg_marker_bits[s] <= i_pwdata[`CTRL_MARK_LSB+:2];
            seg_advance_source[s] <= i_pwdata[`CTRL_ADV_LSB+:2];
            seg_successor[s] <= i_pwdata[`CTRL_SUCC_LSB+:3];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // global registers
  // 33-bit limits span two words, high word holds bit 32
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ramp_enable <= 1'b0;
      limit_low <= `LIMIT_LOW_RST;
      limit_high <= `LIMIT_HIGH_RST;
      ramp_count_limit <= '0;
    end else if (wr) begin
      case (i_paddr)
        `REG_ENABLE: ramp_enable <= i_pwdata[0];
        `REG_LIMIT_LOW_L: limit_low[31:0] <= i_pwdata;
        `REG_LIMIT_LOW_H: limit_low[32] <= i_pwdata[0];
        `REG_LIMIT_HIGH_L: limit_high[31:0] <= i_pwdata;
        `REG_LIMIT_HIGH_H: limit_high[32] <= i_pwdata[0];
        `REG_COUNT: ramp_count_limit <= i_pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  logic tick;
  logic adv;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] clamped;
  logic [2:0] nxt;

  always_comb begin
    tick = (state == st_run) && (ticks_left != '0)
           && (!seg_half_rate[cur] || half_phase);
    case (seg_advance_source[cur])
      // the last tick and the advance share one edge
      adv_length: adv = (ticks_left == '0) ||
                        ((ticks_left == (LEN_W+1)'(1)) && tick);
      adv_event_a: adv = i_event_a;
      adv_event_b: adv = i_event_b;
      adv_event_c: adv = i_event_c;
      default: adv = 1'b0;
    endcase
    adv = adv && (state == st_run);
    sum = accum + {{(ACC_W-STEP_W){seg_step_value[cur][STEP_W-1]}},
                   seg_step_value[cur]};
    // signed compare: limits are two's complement
    if ($signed(sum) < $signed(limit_low)) clamped = limit_low;
    else if ($signed(sum) > $signed(limit_high)) clamped = limit_high;
    else clamped = sum;
    nxt = seg_successor[cur];
  end

  // zero tick count means full 65536
  function automatic logic [LEN_W:0] load_len(input logic [LEN_W-1:0] v);
    load_len = (v == '0) ? {1'b1, {LEN_W{1'b0}}} : {1'b0, v};
  endfunction : load_len

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= st_idle;
      cur <= 3'h0;
      ticks_left <= '0;
      half_phase <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      enable_q <= ramp_enable;
      // dropping enable parks the sequencer at the next edge
      if (!ramp_enable) begin
        state <= st_idle;
      end else if (state == st_idle) begin
        state <= st_run;
        cur <= 3'h0;
        ticks_left <= load_len(seg_tick_count[0]);
        half_phase <= 1'b0;
      end else if (adv) begin
        cur <= nxt;
        ticks_left <= load_len(seg_tick_count[nxt]);
        half_phase <= 1'b0;
      end else begin
        half_phase <= !half_phase;
        if (tick) ticks_left <= ticks_left - (LEN_W+1)'(1);
      end
    end
  end

  // clear on entry beats the last tick of the segment left
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      accum <= '0;
    end else if (ramp_enable && state == st_idle && seg_accum_clear[0]) begin
      accum <= '0;
    end else if (adv && seg_accum_clear[nxt]) begin
      accum <= '0;
    end else if (tick) begin
      accum <= clamped;
    end
  end

  // ramp counter: one count per segment transition
  // a limit of zero disables counting, otherwise it saturates
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ramp_count <= '0;
    end else if (ramp_enable && !enable_q) begin
      ramp_count <= '0;
    end else if (adv && ramp_count_limit != '0
                 && ramp_count != ramp_count_limit) begin
      ramp_count <= ramp_count + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_marker_out_zero <= 1'b0;
      o_marker_out_one <= 1'b0;
      o_fast_settle <= 1'b0;
      o_accum <= '0;
    end else begin
      o_marker_out_zero <= (state == st_run) && seg_marker_bits[cur][0];
      o_marker_out_one <= (state == st_run) && seg_marker_bits[cur][1];
      o_fast_settle <= (state == st_run) && seg_fast_settle[cur];
      o_accum <= accum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read and handshake, answer in the access cycle
  logic [31:0] rd;
  always_comb begin
    // unmapped reads return zero
    rd = 32'h0;
    if (in_seg_area(i_paddr)) begin
      case (i_paddr[4:2])
        `SEG_OFF_STEP: rd[STEP_W-1:0] = seg_step_value[rd_idx];
        `SEG_OFF_LEN: rd[LEN_W-1:0] = seg_tick_count[rd_idx];
        `SEG_OFF_CTRL: begin
          rd[`CTRL_FAST_BIT] = seg_fast_settle[rd_idx];
          rd[`CTRL_HALF_BIT] = seg_half_rate[rd_idx];
          rd[`CTRL_CLEAR_BIT] = seg_accum_clear[rd_idx];
          rd[`CTRL_MARK_LSB+:2] = seg_marker_bits[rd_idx];
          rd[`CTRL_ADV_LSB+:2] = seg_advance_source[rd_idx];
          rd[`CTRL_SUCC_LSB+:3] = seg_successor[rd_idx];
        end
        default: rd = 32'h0;
      endcase
    end else begin
      case (i_paddr)
        `REG_ENABLE: rd[0] = ramp_enable;
        `REG_LIMIT_LOW_L: rd = limit_low[31:0];
        `REG_LIMIT_LOW_H: rd[0] = limit_low[32];
        `REG_LIMIT_HIGH_L: rd = limit_high[31:0];
        `REG_LIMIT_HIGH_H: rd[0] = limit_high[32];
        `REG_COUNT: rd[CNT_W-1:0] = ramp_count_limit;
        `REG_STATUS: rd = {3'h0, ramp_count, 11'h0, cur, 1'b0, state};
        `REG_ACCUM_L: rd = accum[31:0];
        `REG_ACCUM_H: rd[0] = accum[32];
        default: rd = 32'h0;
      endcase
    end
  end

  // one-cycle answer: ready follows every setup cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase && !mapped(i_paddr);
      o_prdata <= (setup_phase && !i_pwrite) ? rd : 32'h0;
    end
  end

endmodule : ramp_segment_sequencer
`default_nettype wire

// ===== dv/ramp_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "ramp_seq_defines.svh"
module ramp_seq_props #(
  parameter int ACC_W = 33
) (
  input wire logic i_mclk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_psel, // select
  input wire logic i_penable, // enable
  input wire logic i_pwrite, // write
  input wire logic [11:0] i_paddr, // address
  input wire logic [31:0] i_pwdata, // wdata
  input wire logic [31:0] o_prdata, // rdata
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic o_marker_out_zero, // marker 0
  input wire logic o_marker_out_one, // marker 1
  input wire logic o_fast_settle, // fast lock
  input wire logic [ACC_W-1:0] o_accum // accumulator
);
  logic en_sh;
  logic [ACC_W-1:0] lo_sh, hi_sh;
  // shadow of enable and limits from bus writes
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_sh <= 1'b0;
      lo_sh <= `LIMIT_LOW_RST;
      hi_sh <= `LIMIT_HIGH_RST;
    end else if (i_psel && i_penable && i_pwrite && o_pready) begin
      case (i_paddr)
        `REG_ENABLE: en_sh <= i_pwdata[0];
        `REG_LIMIT_LOW_L: lo_sh[31:0] <= i_pwdata;
        `REG_LIMIT_LOW_H: lo_sh[ACC_W-1] <= i_pwdata[0];
        `REG_LIMIT_HIGH_L: hi_sh[31:0] <= i_pwdata;
        `REG_LIMIT_HIGH_H: hi_sh[ACC_W-1] <= i_pwdata[0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_setup; i_psel && !i_penable; endsequence
  sequence s_access; i_psel && i_penable; endsequence
  sequence s_idle4; (!en_sh)[*4]; endsequence
  property p_setup_ready; s_setup |=> o_pready; endproperty
  property p_ready_once; o_pready |-> s_access ##1 !o_pready; endproperty
  property p_err_zero; o_pslverr |-> o_pready && o_prdata == 0; endproperty
  property p_rest_zero; !o_pready |-> o_prdata == 0 && !o_pslverr;
  endproperty
  property p_unmapped;
    i_psel && i_penable && o_pready && i_paddr < 12'h100
      && i_paddr > `REG_ACCUM_H |-> o_pslverr;
  endproperty
  property p_idle_out;
    s_idle4 |-> !(o_marker_out_zero || o_marker_out_one || o_fast_settle);
  endproperty
  property p_idle_accum; s_idle4 |-> $stable(o_accum); endproperty
  property p_clamp;
    $changed(o_accum) && o_accum != 0
      |-> $signed(o_accum) >= $signed(lo_sh)
      && $signed(o_accum) <= $signed(hi_sh);
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready");
  a_ready_once: assert property (p_ready_once) else $error("bad ready");
  a_err_zero: assert property (p_err_zero) else $error("error data");
  a_rest_zero: assert property (p_rest_zero) else $error("stray data");
  a_unmapped: assert property (p_unmapped) else $error("no error");
  a_idle_out: assert property (p_idle_out)
    else $error("idle outputs set");
  a_idle_accum: assert property (p_idle_accum)
    else $error("idle accumulator moved");
  a_clamp: assert property (p_clamp)
    else $error("accumulator out of limits");
endmodule : ramp_seq_props
`default_nettype wire

// ===== dv/ramp_segment_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ramp_seq_defines.svh"
module ramp_segment_sequencer_test;
  logic i_mclk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_event_a = 0, i_event_b = 0, i_event_c = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, rd;
  wire logic [31:0] o_prdata;
  wire logic o_pready, o_pslverr, o_marker_out_zero, o_marker_out_one;
  wire logic o_fast_settle;
  wire logic [32:0] o_accum;
  logic [32:0] a;
  logic er, f;
  int err_total = 0, checks_done = 0, cyc = 0, n;
  typedef struct {logic w; logic [11:0] ad; logic [31:0] d, q; logic e;}
    row_type;
  row_type rows[$] = '{
    '{0, `REG_ENABLE, 0, 0, 0}, '{0, `REG_LIMIT_HIGH_L, 0, '1, 0},
    '{0, `REG_LIMIT_HIGH_H, 0, 0, 0}, '{0, `REG_LIMIT_LOW_L, 0, 0, 0},
    '{0, 12'h1E8, 0, 0, 0}, '{0, 12'h024, 0, 0, 1},
    '{1, 12'h1E0, 32'h3FFFFFFF, 0, 0}, '{0, 12'h1E0, 0, 32'h3FFFFFFF, 0},
    '{1, 12'h1C8, 32'h7337, 0, 0}, '{0, 12'h1C8, 0, 32'h7337, 0},
    '{0, 12'h1A8, 0, 0, 0}};
  ramp_segment_sequencer DUT (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_event_a(i_event_a),
    .i_event_b(i_event_b), .i_event_c(i_event_c),
    .o_marker_out_zero(o_marker_out_zero),
    .o_marker_out_one(o_marker_out_one), .o_fast_settle(o_fast_settle),
    .o_accum(o_accum));
  initial forever #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  // waits for a marker pattern, then counts how long it stands
  task automatic seg(input logic [1:0] m);
    int t;
    t = 0;
    n = 0;
    while ({o_marker_out_one, o_marker_out_zero} !== m && t < 300) begin
      @(posedge i_mclk);
      #1 t++;
    end
    a = o_accum;
    f = o_fast_settle;
    while ({o_marker_out_one, o_marker_out_zero} === m && n < 300) begin
      n++;
      @(posedge i_mclk);
      #1;
    end
  endtask : seg
  task automatic pulse(input logic [2:0] m);
    @(posedge i_mclk);
    {i_event_c, i_event_b, i_event_a} <= m;
    @(posedge i_mclk);
    {i_event_c, i_event_b, i_event_a} <= 3'h0;
  endtask : pulse
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].ad, rows[i].d);
      if (!rows[i].w) chk(33'(rd), 33'(rows[i].q));
      chk(33'(er), 33'(rows[i].e));
    end
    $display("done: register table");
    apb(1, `REG_COUNT, 2);
    apb(1, 12'h100, 5);
    apb(1, 12'h104, 2);
    apb(1, 12'h108, 32'h1015);
    apb(1, 12'h120, 32'h3FFFFFFF);
    apb(1, 12'h124, 3);
    apb(1, 12'h128, 32'h22);
    apb(1, `REG_ENABLE, 1);
    seg(2'b01);
    chk(33'(n), 33'd2);
    chk(33'(f), 33'd1);
    seg(2'b10);
    chk(33'(n), 33'd6);
    chk(a, 33'd10);
    chk(33'(f), 33'd0);
    seg(2'b01);
    chk(a, 33'd0);
    apb(0, `REG_STATUS, 0);
    chk(33'(rd[28:16]), 33'd2);
    $display("done: length ramp");
    apb(1, 12'h144, 0);
    apb(1, 12'h148, 32'h10);
    for (int k = 1; k < 4; k++) begin
      apb(1, `REG_ENABLE, 0);
      apb(1, 12'h108, 32'h2030 | 32'(k << 8));
      apb(1, `REG_ENABLE, 1);
      pulse(~(3'h1 << (k - 1)));
      repeat (4) @(posedge i_mclk);
      #1 chk(33'({o_marker_out_one, o_marker_out_zero}), 33'd3);
      pulse(3'h1 << (k - 1));
      repeat (2) @(posedge i_mclk);
      #1 chk(33'({o_marker_out_one, o_marker_out_zero}), 33'd1);
      apb(0, `REG_STATUS, 0);
      chk(33'(rd[4:2]), 33'd2);
      chk(33'(rd[28:16]), 33'd1);
    end
    $display("done: event advance");
    apb(1, `REG_ENABLE, 0);
    apb(1, `REG_LIMIT_HIGH_L, 20);
    apb(1, 12'h100, 7);
    apb(1, 12'h104, 8);
    apb(1, 12'h108, 32'h104);
    apb(1, `REG_ENABLE, 1);
    repeat (10) @(posedge i_mclk);
    #1 chk(o_accum, 33'd20);
    $display("done: clamp");
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 chk(o_accum, 33'd0);
    chk(33'({o_marker_out_one, o_marker_out_zero, o_fast_settle}), 33'd0);
    $display("done: reset");
    report_and_stop();
  end
endmodule : ramp_segment_sequencer_test
bind ramp_segment_sequencer ramp_seq_props #(.ACC_W(ACC_W)) u_props (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_marker_out_zero(o_marker_out_zero),
  .o_marker_out_one(o_marker_out_one), .o_fast_settle(o_fast_settle),
  .o_accum(o_accum));
`default_nettype wire
